// ==== design/etsr_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "etsr_defines.svh"

module etsr_top #(
    parameter int NUM_UNITS = 2,
    parameter int NUM_SAMPLES = `ETSR_NUM_SAMPLES
) (
    input wire logic clock, // 10 MHz system clock
    input wire logic resetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic [NUM_UNITS-1:0] event_in, // event inputs, one per unit
    input wire logic [2:0] event_slot [NUM_UNITS], // 8 ns slot per unit
    input wire logic [31:0] now_seconds, // time of day, seconds
    input wire logic [29:0] now_nanoseconds // time of day, nanoseconds
);
    import etsr_pkg::*;

    // =====================================================
    // per-unit control and units
    logic [NUM_UNITS-1:0] rise_detect_enable;
    logic [NUM_UNITS-1:0] fall_detect_enable;
    logic unit_ptr;
    etsr_sample_t samples [NUM_UNITS][NUM_SAMPLES];
    logic [3:0] counts [NUM_UNITS];
    logic [NUM_UNITS-1:0] overflow;
    logic setup;
    logic wr_en;

    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & pready;

    genvar u;
    generate
        for (u = 0; u < NUM_UNITS; u++) begin : g_unit
            etsr_unit #(.NUM_SAMPLES(NUM_SAMPLES)) u_unit (
                .clock(clock),
                .resetn(resetn),
                .event_in(event_in[u]),
                .event_slot(event_slot[u]),
                .now_seconds(now_seconds),
                .now_nanoseconds(now_nanoseconds),
                .rise_detect_enable(rise_detect_enable[u]),
                .fall_detect_enable(fall_detect_enable[u]),
                .samples(samples[u]),
                .detected_event_count(counts[u]),
                .overflow(overflow[u])
            );

            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    rise_detect_enable[u] <= 1'b0;
                    fall_detect_enable[u] <= 1'b0;
                end else if (wr_en && paddr == `ETSR_OFF_CTRL && unit_ptr == 1'(u)) begin
                    rise_detect_enable[u] <= pwdata[`ETSR_RISE_EN_BIT];
                    fall_detect_enable[u] <= pwdata[`ETSR_FALL_EN_BIT];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            unit_ptr <= 1'b0;
        end else if (wr_en && paddr == `ETSR_OFF_UNIT_INDEX) begin
            unit_ptr <= pwdata[`ETSR_UNIT_PTR_BIT];
        end
    end

    // =====================================================
    // read decode
    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            `ETSR_OFF_CTRL, `ETSR_OFF_S1_NS, `ETSR_OFF_S1_SEC, `ETSR_OFF_S1_PHASE,
            `ETSR_OFF_S2_NS, `ETSR_OFF_S2_SEC, `ETSR_OFF_S2_PHASE, `ETSR_OFF_S3_NS,
            `ETSR_OFF_UNIT_INDEX: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] ns_word(input etsr_sample_t s);
        ns_word = {1'b0, s.polarity, s.nanoseconds};
    endfunction

    logic [31:0] next_prdata;
    etsr_sample_t sel [NUM_SAMPLES];

    always_comb begin
        for (int k = 0; k < NUM_SAMPLES; k++) begin
            sel[k] = samples[unit_ptr][k];
        end
    end

    always_comb begin
        next_prdata = `ETSR_RST_WORD;
        case (paddr)
            `ETSR_OFF_CTRL: begin
                next_prdata[`ETSR_CNT_MSB:`ETSR_CNT_LSB] = counts[unit_ptr];
                next_prdata[`ETSR_OVF_BIT] = overflow[unit_ptr];
                next_prdata[`ETSR_RISE_EN_BIT] = rise_detect_enable[unit_ptr];
                next_prdata[`ETSR_FALL_EN_BIT] = fall_detect_enable[unit_ptr];
            end
            `ETSR_OFF_S1_NS: next_prdata = ns_word(sel[0]);
            `ETSR_OFF_S1_SEC: next_prdata = sel[0].seconds;
            `ETSR_OFF_S1_PHASE: next_prdata = {29'h0, sel[0].phase};
            `ETSR_OFF_S2_NS: next_prdata = ns_word(sel[1]);
            `ETSR_OFF_S2_SEC: next_prdata = sel[1].seconds;
            `ETSR_OFF_S2_PHASE: next_prdata = {29'h0, sel[1].phase};
            `ETSR_OFF_S3_NS: next_prdata = ns_word(sel[2]);
            `ETSR_OFF_UNIT_INDEX: next_prdata[`ETSR_UNIT_PTR_BIT] = unit_ptr;
            default: next_prdata = `ETSR_RST_WORD;
        endcase
    end

    // =====================================================
    // apb answer: no wait state, data registered at setup
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `ETSR_RST_WORD;
        end else begin
            pready <= setup;
            pslverr <= setup & ~is_mapped(paddr);
            // writes to sample words are dropped by the decode above
            prdata <= (setup && !pwrite) ? next_prdata : `ETSR_RST_WORD;
        end
    end

    // =====================================================
    // bus handshake checks
    // no wait state, so the master always finds pready in the first access cycle
    ready_one_a: assert property (@(posedge clock) disable iff (!resetn)
        setup |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    ready_access_a: assert property (@(posedge clock) disable iff (!resetn)
        pready |-> psel && penable)
        else $error("pready outside an access phase");
    err_with_ready_a: assert property (@(posedge clock) disable iff (!resetn)
        pslverr |-> pready)
        else $error("pslverr without pready");
    idle_data_a: assert property (@(posedge clock) disable iff (!resetn)
        !pready |-> prdata == `ETSR_RST_WORD)
        else $error("read data outside ready cycle");
    unmapped_err_a: assert property (@(posedge clock) disable iff (!resetn)
        setup && !is_mapped(paddr) |=> pslverr && pready)
        else $error("unmapped address not refused");

    // =====================================================
    // register readout checks
    reserved_zero_a: assert property (@(posedge clock) disable iff (!resetn)
        pready && paddr == `ETSR_OFF_S1_PHASE |-> prdata[31:3] == 29'h0)
        else $error("phase reserved bits not zero");
    ns_top_a: assert property (@(posedge clock) disable iff (!resetn)
        pready && paddr == `ETSR_OFF_S2_NS |-> !prdata[31])
        else $error("nanoseconds bit 31 set");
    phase_code_a: assert property (@(posedge clock) disable iff (!resetn)
        pready && paddr == `ETSR_OFF_S2_PHASE |-> prdata[2:0] <= 3'h4)
        else $error("reserved phase code reported");
    sec_read_a: assert property (@(posedge clock) disable iff (!resetn)
        setup && !pwrite && paddr == `ETSR_OFF_S1_SEC
        |=> prdata == $past(samples[unit_ptr][0].seconds))
        else $error("seconds readout wrong");
    ns_read_a: assert property (@(posedge clock) disable iff (!resetn)
        setup && !pwrite && paddr == `ETSR_OFF_S3_NS
        |=> prdata == {1'b0, $past(samples[unit_ptr][2].polarity),
            $past(samples[unit_ptr][2].nanoseconds)})
        else $error("third nanoseconds readout wrong");
    phase_read_a: assert property (@(posedge clock) disable iff (!resetn)
        setup && !pwrite && paddr == `ETSR_OFF_S2_PHASE
        |=> prdata == {29'h0, $past(samples[unit_ptr][1].phase)})
        else $error("second phase readout wrong");
    status_read_a: assert property (@(posedge clock) disable iff (!resetn)
        setup && !pwrite && paddr == `ETSR_OFF_CTRL
        |=> prdata[`ETSR_CNT_MSB:`ETSR_CNT_LSB] == $past(counts[unit_ptr])
            && prdata[`ETSR_OVF_BIT] == $past(overflow[unit_ptr]))
        else $error("count or overflow readout wrong");
    ptr_read_a: assert property (@(posedge clock) disable iff (!resetn)
        setup && !pwrite && paddr == `ETSR_OFF_UNIT_INDEX
        |=> prdata[`ETSR_UNIT_PTR_BIT] == $past(unit_ptr))
        else $error("unit pointer readout wrong");

    // =====================================================
    // register write checks
    ptr_write_a: assert property (@(posedge clock) disable iff (!resetn)
        wr_en && paddr == `ETSR_OFF_UNIT_INDEX |=> unit_ptr == $past(pwdata[`ETSR_UNIT_PTR_BIT]))
        else $error("unit pointer not updated");
    enable_write_a: assert property (@(posedge clock) disable iff (!resetn)
        wr_en && paddr == `ETSR_OFF_CTRL && unit_ptr == 1'b0
        |=> rise_detect_enable[0] == $past(pwdata[`ETSR_RISE_EN_BIT]))
        else $error("rise enable not written");
    fall_write_a: assert property (@(posedge clock) disable iff (!resetn)
        wr_en && paddr == `ETSR_OFF_CTRL && unit_ptr == 1'b1
        |=> fall_detect_enable[1] == $past(pwdata[`ETSR_FALL_EN_BIT]))
        else $error("fall enable not written");
    // sample words have no write path at all; this checks such writes leave the enables and unit pointer unchanged
    ro_write_a: assert property (@(posedge clock) disable iff (!resetn)
        wr_en && paddr != `ETSR_OFF_CTRL && paddr != `ETSR_OFF_UNIT_INDEX
        |=> $stable(rise_detect_enable) && $stable(fall_detect_enable) && $stable(unit_ptr))
        else $error("write to read-only word changed state");

    read_s2_c: cover property (@(posedge clock) pready && paddr == `ETSR_OFF_S2_SEC);
    unit1_c: cover property (@(posedge clock) unit_ptr && pready && !pwrite);
    ovf_c: cover property (@(posedge clock) overflow[0]);
endmodule

`default_nettype wire

// ==== design/etsr_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "etsr_defines.svh"

// one timestamp input unit: edge detect, sample store, event count
module etsr_unit #(
    parameter int NUM_SAMPLES = `ETSR_NUM_SAMPLES
) (
    input wire logic clock, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic event_in, // synchronous event input
    input wire logic [2:0] event_slot, // 8 ns slot of the edge
    input wire logic [31:0] now_seconds, // time of day, seconds
    input wire logic [29:0] now_nanoseconds, // time of day, nanoseconds
    input wire logic rise_detect_enable, // capture rising edges
    input wire logic fall_detect_enable, // capture falling edges
    output var etsr_pkg::etsr_sample_t samples [NUM_SAMPLES], // stored samples
    output logic [3:0] detected_event_count, // events seen, saturating
    output logic overflow // enabled edge seen with count already at 15
);
    import etsr_pkg::*;

    logic last_in;
    logic rise;
    logic fall;
    logic capture;
    logic [2:0] clean_slot;

    assign rise = event_in & ~last_in & rise_detect_enable;
    assign fall = ~event_in & last_in & fall_detect_enable;
    assign capture = rise | fall;
    // reserved codes never reach the registers
    assign clean_slot = (event_slot > ETSR_SLOT_32NS) ? 3'h0 : event_slot;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            last_in <= 1'b0;
        end else begin
            last_in <= event_in;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_SAMPLES; i++) begin : g_slot
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    samples[i] <= '0;
                end else if (capture && detected_event_count == 4'(i)) begin
                    samples[i].seconds <= now_seconds;
                    samples[i].nanoseconds <= now_nanoseconds;
                    samples[i].phase <= clean_slot;
                    samples[i].polarity <= rise;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            detected_event_count <= 4'h0;
            overflow <= 1'b0;
        end else if (capture) begin
            if (detected_event_count == `ETSR_CNT_MAX) begin
                overflow <= 1'b1;
            end else begin
                detected_event_count <= detected_event_count + 4'h1;
            end
        end
    end

    sat_hold_a: assert property (@(posedge clock) disable iff (!resetn)
        capture && detected_event_count == 4'hf |=> detected_event_count == 4'hf && overflow)
        else $error("count left 15 on overflow");
    no_capture_a: assert property (@(posedge clock) disable iff (!resetn)
        !capture |=> $stable(detected_event_count))
        else $error("count moved without enabled edge");
    edge_sel_a: assert property (@(posedge clock) disable iff (!resetn)
        rise && detected_event_count == 4'h0 |=> samples[0].polarity)
        else $error("rising edge not marked");
    slot_clean_a: assert property (@(posedge clock) disable iff (!resetn)
        capture && detected_event_count == 4'h0 && event_slot > ETSR_SLOT_32NS
        |=> samples[0].phase == 3'h0)
        else $error("reserved phase code stored");
    first_cap_c: cover property (@(posedge clock) disable iff (!resetn)
        capture && detected_event_count == 4'h0);
endmodule

`default_nettype wire

// ==== inc/etsr_defines.svh ====
`ifndef ETSR_DEFINES_SVH
`define ETSR_DEFINES_SVH

// =====================================================
// register offsets (byte addresses)
`define ETSR_OFF_CTRL 12'h550
`define ETSR_OFF_S1_NS 12'h554
`define ETSR_OFF_S1_SEC 12'h558
`define ETSR_OFF_S1_PHASE 12'h55c
`define ETSR_OFF_S2_NS 12'h560
`define ETSR_OFF_S2_SEC 12'h564
`define ETSR_OFF_S2_PHASE 12'h568
`define ETSR_OFF_S3_NS 12'h56c
`define ETSR_OFF_UNIT_INDEX 12'h600

// =====================================================
// field positions
`define ETSR_NS_MSB 29
`define ETSR_EDGE_BIT 30
`define ETSR_PHASE_MSB 2
`define ETSR_RISE_EN_BIT 7
`define ETSR_FALL_EN_BIT 6
`define ETSR_OVF_BIT 16
`define ETSR_CNT_LSB 17
`define ETSR_CNT_MSB 20
`define ETSR_UNIT_PTR_BIT 8

// =====================================================
// reset values and limits
`define ETSR_RST_WORD 32'h0000_0000
`define ETSR_CNT_MAX 4'hf
`define ETSR_NUM_SAMPLES 3

`endif

// ==== inc/etsr_pkg.sv ====
`default_nettype none

package etsr_pkg;
    typedef enum logic [2:0] {
        ETSR_SLOT_0NS = 3'h0,
        ETSR_SLOT_8NS = 3'h1,
        ETSR_SLOT_16NS = 3'h2,
        ETSR_SLOT_24NS = 3'h3,
        ETSR_SLOT_32NS = 3'h4
    } etsr_slot_t;

    typedef struct packed {
        logic [31:0] seconds;
        logic [29:0] nanoseconds;
        logic [2:0] phase;
        logic polarity;
    } etsr_sample_t;
endpackage

`default_nettype wire

// ==== tb/etsr_event_src.sv ====
`timescale 1ns/100ps
`default_nettype none

// =====================================================
// external event source driving the timestamp units
module etsr_event_src #(
    parameter int NUM_UNITS = 2
) (
    input wire logic clock, // system clock
    output logic [NUM_UNITS-1:0] event_in, // event levels
    output logic [2:0] event_slot [NUM_UNITS] // slot code with each edge
);
    initial begin
        event_in = '0;
        for (int i = 0; i < NUM_UNITS; i++) begin
            event_slot[i] = 3'h5;
        end
    end

    // slot is only valid in the edge cycle; scrambled after so stale codes never match
    task automatic drive(input int u, input logic lvl, input logic [2:0] sl);
        @(posedge clock);
        event_in[u] <= lvl;
        event_slot[u] <= sl;
        @(posedge clock);
        event_slot[u] <= ~sl;
    endtask
endmodule

`default_nettype wire

// ==== tb/event_timestamp_sample_readout_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module event_timestamp_sample_readout_tb_top;
    import etsr_pkg::*;
    localparam int TIMEOUT_CYCLES = 3000;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, now_seconds;
    logic pready, pslverr;
    logic [29:0] now_nanoseconds;
    logic [1:0] event_in;
    logic [2:0] event_slot [2];
    int failures = 0;
    int compares = 0;
    int cycles = 0;

    always #50 clock = ~clock;

    etsr_top #(.NUM_UNITS(2)) DUT (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
        .event_slot(event_slot), .now_seconds(now_seconds),
        .now_nanoseconds(now_nanoseconds));

    etsr_event_src #(.NUM_UNITS(2)) src (.clock(clock), .event_in(event_in),
        .event_slot(event_slot));

    function automatic logic [29:0] ns_of(input logic [31:0] s);
        return s[29:0] + 30'h2000;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; waits for pready, takes data at that edge only
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] exp, input logic xerr);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // no wait count assumed; only the bench timeout ends a hung wait
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        chk("prdata", prdata, wr ? 32'h0 : exp);
        chk("pslverr", {31'h0, pslverr}, {31'h0, xerr});
    endtask

    // time of day held steady around the edge so the capture cycle does not matter
    task automatic ev(input int u, input logic lvl, input logic [2:0] sl,
            input logic [31:0] s);
        @(posedge clock);
        now_seconds <= s;
        now_nanoseconds <= ns_of(s);
        src.drive(u, lvl, sl);
        repeat (3) @(posedge clock);
    endtask

    task automatic results;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYCLES) begin
            failures++;
            results();
        end
    end

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        now_seconds = 32'h0;
        now_nanoseconds = 30'h0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            xfer(1'b0, 12'h550 + 12'(4 * a), 32'h0, 32'h0, 1'b0);
        end
        $display("test reset values done");
        ev(0, 1'b1, 3'h1, 32'h101);
        xfer(1'b1, 12'h550, 32'h80, 32'h0, 1'b0);
        ev(0, 1'b0, 3'h4, 32'h102);
        ev(0, 1'b1, 3'h3, 32'h103);
        ev(0, 1'b0, 3'h4, 32'h104);
        ev(0, 1'b1, 3'h2, 32'h105);
        xfer(1'b1, 12'h550, 32'hc0, 32'h0, 1'b0);
        ev(0, 1'b0, 3'h1, 32'h106);
        xfer(1'b0, 12'h550, 32'h0006_00c0, 32'h0006_00c0, 1'b0);
        xfer(1'b0, 12'h554, {2'b01, ns_of(32'h103)}, {2'b01, ns_of(32'h103)}, 1'b0);
        xfer(1'b0, 12'h558, 32'h0, 32'h103, 1'b0);
        xfer(1'b0, 12'h55c, 32'h0, 32'h3, 1'b0);
        xfer(1'b0, 12'h560, 32'h0, {2'b01, ns_of(32'h105)}, 1'b0);
        xfer(1'b0, 12'h564, 32'h0, 32'h105, 1'b0);
        xfer(1'b0, 12'h568, 32'h0, 32'h2, 1'b0);
        xfer(1'b0, 12'h56c, 32'h0, {2'b00, ns_of(32'h106)}, 1'b0);
        $display("test capture done");
        xfer(1'b1, 12'h558, 32'hffff_ffff, 32'h0, 1'b0);
        xfer(1'b1, 12'h56c, 32'hffff_ffff, 32'h0, 1'b0);
        xfer(1'b0, 12'h558, 32'h0, 32'h103, 1'b0);
        xfer(1'b0, 12'h56c, 32'h0, {2'b00, ns_of(32'h106)}, 1'b0);
        xfer(1'b0, 12'h700, 32'h0, 32'h0, 1'b1);
        $display("test read only done");
        for (int k = 0; k < 12; k++) begin
            ev(0, k[0] == 1'b0, 3'h3, 32'h300);
        end
        xfer(1'b0, 12'h550, 32'h0, 32'h001e_00c0, 1'b0);
        // input is low after twelve toggles, so the sixteenth edge is a rise
        ev(0, 1'b1, 3'h3, 32'h300);
        xfer(1'b0, 12'h550, 32'h0, 32'h001f_00c0, 1'b0);
        xfer(1'b0, 12'h558, 32'h0, 32'h103, 1'b0);
        $display("test count done");
        xfer(1'b1, 12'h600, 32'h100, 32'h0, 1'b0);
        xfer(1'b0, 12'h600, 32'h0, 32'h100, 1'b0);
        xfer(1'b0, 12'h558, 32'h0, 32'h0, 1'b0);
        xfer(1'b1, 12'h550, 32'hc0, 32'h0, 1'b0);
        ev(1, 1'b1, 3'h4, 32'h201);
        // reserved slot code at the edge must not reach the phase word
        ev(1, 1'b0, 3'h7, 32'h202);
        xfer(1'b0, 12'h558, 32'h0, 32'h201, 1'b0);
        xfer(1'b0, 12'h55c, 32'h0, 32'h4, 1'b0);
        xfer(1'b0, 12'h560, 32'h0, {2'b00, ns_of(32'h202)}, 1'b0);
        xfer(1'b0, 12'h568, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, 12'h550, 32'h0, 32'h0004_00c0, 1'b0);
        xfer(1'b1, 12'h600, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, 12'h558, 32'h0, 32'h103, 1'b0);
        $display("test unit select done");
        results();
    end
endmodule

`default_nettype wire
